// ===== verilog/ecr_defines.svh
// offsets, field positions, reset values and timing counts for the enable regs
`ifndef ECR_DEFINES_SVH
`define ECR_DEFINES_SVH
`define ECR_FUNC_EN_ADDR      8'hD5
`define ECR_CLK_EN_ADDR       8'hD6
`define ECR_FUNC_EN_RST       8'h00
`define ECR_CLK_EN_RST        8'h00
`define ECR_FUNC_EN_MASK      8'h1F
`define ECR_CLK_EN_MASK       8'h07
`define ECR_SW_WD_BIT         0
`define ECR_OSC_WD_BIT        1
`define ECR_CAP_FLAG_BIT      2
`define ECR_LOOPBACK_BIT      3
`define ECR_TEST_CAPS_BIT     4
`define ECR_EE_CLK_BIT        0
`define ECR_IF_CLK_BIT        1
`define ECR_RAM_BIST_BIT      2
`define ECR_CLK_PERIOD_NS     10
`define ECR_SEL_LOW_NS        50
`define ECR_SEL_LOW_CYC       ((`ECR_SEL_LOW_NS + `ECR_CLK_PERIOD_NS - 1) / `ECR_CLK_PERIOD_NS)
`endif

// ===== verilog/ecr_pkg.sv
// types shared by the enable control register bank
package ecr_pkg;
   typedef enum logic [1:0] {
      ECR_MODE_RES_BRIDGE,
      ECR_MODE_CAP
   } ecr_sense_mode_t;
endpackage

// ===== verilog/ecr_low_detect.sv
// counts consecutive low cycles of a select input and flags a held low
`timescale 1ns/1ps
`include "ecr_defines.svh"
module ecr_low_detect
(
   input  wire logic mclk_i,
   input  wire logic nrst_i,
   input  wire logic ce_i,
   input  wire logic level_n_i,
   output logic      held_o
);
   localparam logic [3:0] LIMIT = 4'(`ECR_SEL_LOW_CYC);
   logic [3:0] cnt_q;

   // saturating count; any high cycle with ce_i set restarts it, so glitches shorter
   // than the limit never fire
   always_ff @(posedge mclk_i)
   begin
      if (!nrst_i)
         cnt_q <= 4'h0;
      else if (ce_i)
      begin
         if (level_n_i)
            cnt_q <= 4'h0;
         else if (cnt_q != LIMIT)
            cnt_q <= cnt_q + 4'h1;
      end
   end

   assign held_o = (cnt_q == LIMIT); // RQ10
endmodule

// ===== verilog/ecr_enable_regs.sv
// two enable control registers on the cpu's extended sfr port
// Functional notes
// [RQ1] function reg bit 0 switches the software watchdog on or off
// [RQ2] function reg bit 1 switches the oscillator watchdog on or off
// [RQ3] function reg bit 2 enables cap sensor clock high/low flags
// [RQ4] function reg bit 3 enables dac loopback in both sensing modes; the code forces resistive bridge mode while it is set
// [RQ5] loopback forces the front end into resistive bridge mode
// [RQ6] function reg bit 4 selects internal test caps over external caps
// [RQ7] clock reg bit 0 gates eeprom clock; cleared blocks eeprom access
// [RQ8] clock reg bit 1 gates interface clock; cleared stops interfaces
// [RQ9] one-wire activation interrupt sets the interface clock bit
// [RQ10] select low five consecutive clocks sets the interface clock bit
// [RQ11] clock reg bit 2 starts ram self test and cuts cpu ram access
// [RQ12] unused bits read zero and writes to them have no effect
`timescale 1ns/1ps
`include "ecr_defines.svh"
module ecr_enable_regs
(
   input  wire logic                   mclk_i,
   input  wire logic                   nrst_i,
   input  wire logic                   ce_i,
   input  wire logic [7:0]             sfr_addr_i,
   input  wire logic [7:0]             sfr_wdata_i,
   input  wire logic                   sfr_wr_i,
   input  wire logic                   sfr_rd_i,
   output logic      [7:0]             sfr_rdata_o,
   output logic                        sfr_sel_o,
   input  wire logic                   one_wire_link_act_i,
   input  wire logic                   spi_select_n_i,
   input  wire ecr_pkg::ecr_sense_mode_t sense_mode_i,
   input  wire logic                   ee_req_i,
   input  wire logic                   cpu_ram_req_i,
   output logic                        sw_watchdog_enable_o,
   output logic                        osc_watchdog_enable_o,
   output logic                        cap_clock_flag_enable_o,
   output logic                        dac_loopback_enable_o,
   output logic                        test_caps_select_o,
   output ecr_pkg::ecr_sense_mode_t    afe_mode_o,
   output logic                        ee_clock_enable_o,
   output logic                        ee_req_o,
   output logic                        host_interface_clock_enable_o,
   output logic                        ram_selftest_enable_o,
   output logic                        cpu_ram_req_o
);
   logic [7:0] func_q;
   logic [7:0] clk_q;
   logic       func_hit;
   logic       clk_hit;
   logic       sel_held;

   // every check below runs on the core clock and sleeps through reset
   default clocking ecr_cb @(posedge mclk_i);
   endclocking
   default disable iff (!nrst_i);

   assign func_hit = (sfr_addr_i == `ECR_FUNC_EN_ADDR);
   assign clk_hit  = (sfr_addr_i == `ECR_CLK_EN_ADDR);
   assign sfr_sel_o = func_hit | clk_hit; // tells the cpu mux to take us

   // held-low filter on the spi select pin
   ecr_low_detect u_sel_detect
   (
      .mclk_i    (mclk_i),
      .nrst_i    (nrst_i),
      .ce_i      (ce_i),
      .level_n_i (spi_select_n_i),
      .held_o    (sel_held)
   );

   // function enable register; unimplemented bits are masked on write
   always_ff @(posedge mclk_i)
   begin
      if (!nrst_i)
         func_q <= `ECR_FUNC_EN_RST;
      else if (ce_i && sfr_wr_i && func_hit)
         func_q <= sfr_wdata_i & `ECR_FUNC_EN_MASK; // RQ12
   end

   // clock enable register; hardware set of the interface clock wins over
   // a software clear in the same cycle so no activation is lost
   always_ff @(posedge mclk_i)
   begin
      if (!nrst_i)
         clk_q <= `ECR_CLK_EN_RST;
      else if (ce_i)
      begin
         if (sfr_wr_i && clk_hit)
            clk_q <= sfr_wdata_i & `ECR_CLK_EN_MASK; // RQ12
         if (one_wire_link_act_i || sel_held)
            clk_q[`ECR_IF_CLK_BIT] <= 1'b1; // RQ9 RQ10
      end
   end

   // read data registered so a byte stays put until the next read
   always_ff @(posedge mclk_i)
   begin
      if (!nrst_i)
         sfr_rdata_o <= 8'h00;
      else if (ce_i && sfr_rd_i)
         sfr_rdata_o <= func_hit ? func_q : (clk_hit ? clk_q : 8'h00);
   end

   // enables straight from the flops
   assign sw_watchdog_enable_o    = func_q[`ECR_SW_WD_BIT]; // RQ1
   assign osc_watchdog_enable_o   = func_q[`ECR_OSC_WD_BIT]; // RQ2
   assign cap_clock_flag_enable_o = func_q[`ECR_CAP_FLAG_BIT]; // RQ3
   assign dac_loopback_enable_o   = func_q[`ECR_LOOPBACK_BIT]; // RQ4
   assign test_caps_select_o      = func_q[`ECR_TEST_CAPS_BIT]; // RQ6

   // loopback overrides the configured sensing mode
   assign afe_mode_o = func_q[`ECR_LOOPBACK_BIT] ?
                       ecr_pkg::ECR_MODE_RES_BRIDGE : sense_mode_i; // RQ5

   // clock gates and access blocking
   assign ee_clock_enable_o = clk_q[`ECR_EE_CLK_BIT]; // RQ7
   assign ee_req_o = ee_req_i & clk_q[`ECR_EE_CLK_BIT]; // RQ7
   assign host_interface_clock_enable_o = clk_q[`ECR_IF_CLK_BIT]; // RQ8
   assign ram_selftest_enable_o = clk_q[`ECR_RAM_BIST_BIT]; // RQ11
   assign cpu_ram_req_o = cpu_ram_req_i & ~clk_q[`ECR_RAM_BIST_BIT]; // RQ11

   // strokes the cpu completes on this edge
   sequence func_write;
      ce_i && sfr_wr_i && func_hit;
   endsequence

   sequence clk_write;
      ce_i && sfr_wr_i && clk_hit;
   endsequence

   // five low edges arm the filter; the next enabled edge applies the set
   sequence sel_held_low;
      (ce_i && !spi_select_n_i) [*5] ##1 ce_i;
   endsequence

   // every function bit follows the byte written one edge earlier
   sw_wd_write_a : assert property (func_write |=> // RQ1
      sw_watchdog_enable_o == $past(sfr_wdata_i[`ECR_SW_WD_BIT]))
      else $error("software watchdog enable differs from write");

   osc_wd_write_a : assert property (func_write |=> // RQ2
      osc_watchdog_enable_o == $past(sfr_wdata_i[`ECR_OSC_WD_BIT]))
      else $error("oscillator watchdog enable differs from write");

   cap_flag_write_a : assert property (func_write |=> // RQ3
      cap_clock_flag_enable_o == $past(sfr_wdata_i[`ECR_CAP_FLAG_BIT]))
      else $error("cap flag enable differs from write");

   loop_write_a : assert property (func_write |=> // RQ4
      dac_loopback_enable_o == $past(sfr_wdata_i[`ECR_LOOPBACK_BIT]))
      else $error("loopback enable differs from write");

   caps_sel_a : assert property (func_write |=> // RQ6
      test_caps_select_o == $past(sfr_wdata_i[`ECR_TEST_CAPS_BIT]))
      else $error("test caps select differs from write");

   // the override must win, and must let go once loopback is off
   loop_mode_a : assert property ( // RQ5
      dac_loopback_enable_o |-> afe_mode_o == ecr_pkg::ECR_MODE_RES_BRIDGE)
      else $error("loopback did not force bridge mode");

   pass_mode_a : assert property ( // RQ5
      !dac_loopback_enable_o |-> afe_mode_o == sense_mode_i)
      else $error("configured mode not passed through");

   // clock register bits, with no hardware set racing the write
   ee_clk_write_a : assert property (clk_write |=> // RQ7
      ee_clock_enable_o == $past(sfr_wdata_i[`ECR_EE_CLK_BIT]))
      else $error("eeprom clock enable differs from write");

   if_clk_write_a : assert property ( // RQ8
      ce_i && sfr_wr_i && clk_hit && !one_wire_link_act_i && !sel_held
      |=> host_interface_clock_enable_o ==
          $past(sfr_wdata_i[`ECR_IF_CLK_BIT]))
      else $error("interface clock enable differs from write");

   bist_write_a : assert property (clk_write |=> // RQ11
      ram_selftest_enable_o == $past(sfr_wdata_i[`ECR_RAM_BIST_BIT]))
      else $error("self test enable differs from write");

   // gates: eeprom blocked while its clock enable is off and transparent while on; cpu ram blocked while self test is on
   ee_block_a : assert property ( // RQ7
      !ee_clock_enable_o |-> !ee_req_o)
      else $error("eeprom access passed while clock off");

   ee_pass_a : assert property ( // RQ7
      ee_clock_enable_o |-> ee_req_o == ee_req_i)
      else $error("eeprom request lost while clock on");

   ram_block_a : assert property ( // RQ11
      ram_selftest_enable_o |-> !cpu_ram_req_o)
      else $error("cpu reached ram during self test");

   ram_pass_a : assert property ( // RQ11
      !ram_selftest_enable_o |-> cpu_ram_req_o == cpu_ram_req_i)
      else $error("cpu ram request lost outside self test");

   // hardware wake-ups; the set must survive a same-cycle software clear
   owi_wake_a : assert property ( // RQ9
      ce_i && one_wire_link_act_i |=> host_interface_clock_enable_o)
      else $error("one-wire activation did not set clock");

   sel_wake_a : assert property ( // RQ10
      sel_held_low |=> host_interface_clock_enable_o)
      else $error("held select did not set clock");

   // unused bits and foreign addresses read as zero
   unused_zero_a : assert property ( // RQ12
      (func_q[7:5] == 3'h0) && (clk_q[7:3] == 5'h0))
      else $error("unused bits not zero");

   rd_func_a : assert property ( // RQ12
      ce_i && sfr_rd_i && func_hit |=> sfr_rdata_o == $past(func_q))
      else $error("function register read back wrong");

   rd_clk_a : assert property ( // RQ12
      ce_i && sfr_rd_i && clk_hit |=> sfr_rdata_o == $past(clk_q))
      else $error("clock register read back wrong");

   rd_other_a : assert property ( // RQ12
      ce_i && sfr_rd_i && !sfr_sel_o |=> sfr_rdata_o == 8'h00)
      else $error("foreign address did not read zero");

   rd_hold_a : assert property ( // RQ12
      !(ce_i && sfr_rd_i) |=> $stable(sfr_rdata_o))
      else $error("read data moved without a read");
endmodule

// ===== test/tb_top.sv
// self-checking bench for the enable control register bank
`timescale 1ns/1ps
`include "ecr_defines.svh"
module tb_top;
   logic                     mclk_i = 1'b0, nrst_i = 1'b0, ce_i = 1'b1;
   logic                     wr = 1'b0, rd = 1'b0, one_wire_link = 1'b0, sel_n = 1'b1;
   logic                     eer = 1'b0, ramr = 1'b0, sel, eq, rq;
   logic                     sw, osc, capf, lb, tc, eck, ifc, bist;
   logic [7:0]               addr = 8'h00, wdata = 8'h00, rdata;
   logic [7:0]               f = 8'h00, c = 8'h00; // model registers
   ecr_pkg::ecr_sense_mode_t mode = ecr_pkg::ECR_MODE_CAP, afe;
   int                       num_errors = 0, checks_done = 0, cyc = 0, i;
   ecr_enable_regs u_dut (.mclk_i(mclk_i), .nrst_i(nrst_i), .ce_i(ce_i),
      .sfr_addr_i(addr), .sfr_wdata_i(wdata), .sfr_wr_i(wr), .sfr_rd_i(rd),
      .sfr_rdata_o(rdata), .sfr_sel_o(sel), .one_wire_link_act_i(one_wire_link),
      .spi_select_n_i(sel_n), .sense_mode_i(mode), .ee_req_i(eer),
      .cpu_ram_req_i(ramr), .sw_watchdog_enable_o(sw),
      .osc_watchdog_enable_o(osc), .cap_clock_flag_enable_o(capf),
      .dac_loopback_enable_o(lb), .test_caps_select_o(tc), .afe_mode_o(afe),
      .ee_clock_enable_o(eck), .ee_req_o(eq),
      .host_interface_clock_enable_o(ifc), .ram_selftest_enable_o(bist),
      .cpu_ram_req_o(rq));
   // free-running 100 MHz clock
   initial forever #5 mclk_i = ~mclk_i;
   // hang guard: runs well past the few hundred cycles the tests need
   always @(posedge mclk_i)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         num_errors++;
         wrap_up;
      end
   end
   task automatic cmp_rd(input logic [7:0] g, input logic [7:0] e);
      checks_done++;
      if (g !== e)
      begin
         num_errors++;
         $display("CHECK FAILED %0t read %h exp %h", $time, g, e);
      end
   endtask
   task automatic cmp_out(input logic [12:0] g, input logic [12:0] e);
      checks_done++;
      if (g !== e)
      begin
         num_errors++;
         $display("CHECK FAILED %0t outs %h exp %h", $time, g, e);
      end
   endtask
   // all enable levels, gates and the mode override against the model
   task automatic chk_out;
      cmp_out({sel, afe, eq, rq, bist, ifc, eck, tc, lb, capf, osc, sw},
         {(addr == `ECR_FUNC_EN_ADDR) || (addr == `ECR_CLK_EN_ADDR),
          f[3] ? ecr_pkg::ECR_MODE_RES_BRIDGE : mode,
          eer & c[0], ramr & ~c[2], c[2:0], f[4:0]});
   endtask
   // the model only takes the write when the clock enable is high
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(negedge mclk_i) {addr, wdata, wr} = {a, d, 1'b1};
      @(negedge mclk_i) wr = 1'b0;
      if (ce_i && a == `ECR_FUNC_EN_ADDR) f = d & `ECR_FUNC_EN_MASK;
      if (ce_i && a == `ECR_CLK_EN_ADDR) c = d & `ECR_CLK_EN_MASK;
   endtask
   task automatic rd_chk(input logic [7:0] a);
      @(negedge mclk_i) {addr, rd} = {a, 1'b1};
      @(negedge mclk_i) rd = 1'b0;
      cmp_rd(rdata, a == `ECR_FUNC_EN_ADDR ? f : a == `ECR_CLK_EN_ADDR ? c
         : 8'h00);
   endtask
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // main sequence
   initial
   begin
      void'($urandom(32'h3EDC8B76));
      repeat (10) @(negedge mclk_i);
      nrst_i = 1'b1;
      rd_chk(`ECR_FUNC_EN_ADDR);
      rd_chk(`ECR_CLK_EN_ADDR);
      rd_chk(8'h00);
      chk_out;
      $display("test reset done");
      for (i = 0; i < 30; i++)
      begin
         mode = ecr_pkg::ecr_sense_mode_t'($urandom_range(1, 0));
         {eer, ramr} = 2'($urandom);
         wr_reg(i % 3 == 0 ? `ECR_FUNC_EN_ADDR : i % 3 == 1 ?
            `ECR_CLK_EN_ADDR : 8'($urandom), 8'($urandom));
         chk_out;
         rd_chk(`ECR_FUNC_EN_ADDR);
         rd_chk(`ECR_CLK_EN_ADDR);
      end
      $display("test random done");
      ce_i = 1'b0;
      wr_reg(`ECR_FUNC_EN_ADDR, 8'hFF);
      ce_i = 1'b1;
      rd_chk(`ECR_FUNC_EN_ADDR);
      wr_reg(`ECR_CLK_EN_ADDR, 8'h00);
      @(negedge mclk_i) one_wire_link = 1'b1;
      @(negedge mclk_i) one_wire_link = 1'b0;
      c[1] = 1'b1;
      chk_out;
      $display("test one wire done");
      wr_reg(`ECR_CLK_EN_ADDR, 8'h00);
      // a short select pulse must not wake the interface clock
      @(negedge mclk_i) sel_n = 1'b0;
      repeat (4) @(negedge mclk_i);
      sel_n = 1'b1;
      chk_out;
      // five low edges arm the filter and the next edge sets the bit
      @(negedge mclk_i) sel_n = 1'b0;
      repeat (5) @(negedge mclk_i);
      sel_n = 1'b1;
      chk_out;
      @(negedge mclk_i) c[1] = 1'b1;
      chk_out;
      rd_chk(`ECR_CLK_EN_ADDR);
      $display("test select done");
      // a reset in mid-run returns both registers to their reset values
      wr_reg(`ECR_FUNC_EN_ADDR, 8'h1F);
      @(negedge mclk_i) nrst_i = 1'b0;
      repeat (2) @(negedge mclk_i);
      nrst_i = 1'b1;
      {f, c} = {`ECR_FUNC_EN_RST, `ECR_CLK_EN_RST};
      chk_out;
      rd_chk(`ECR_FUNC_EN_ADDR);
      rd_chk(`ECR_CLK_EN_ADDR);
      $display("test mid-run reset done");
      wrap_up;
   end
endmodule
